// ### design/egqs_regs.vh
`ifndef EGQS_REGS_VH
`define EGQS_REGS_VH

// Register indexes; byte address is four times the index
`define EGQS_IDX_P1_Q2_RATE 8'h9C
`define EGQS_IDX_P1_Q3_RATE 8'h9D
`define EGQS_IDX_P2_Q2_RATE 8'hA0
`define EGQS_IDX_P2_Q3_RATE 8'hA1
`define EGQS_IDX_P3_Q1_RATE 8'hA3
`define EGQS_IDX_P3_Q2_RATE 8'hA4
`define EGQS_IDX_P3_Q3_RATE 8'hA5
`define EGQS_IDX_CFG_REPORT 8'hA6
`define EGQS_IDX_Q3_RESERVE 8'hA7
`define EGQS_IDX_Q2_RESERVE 8'hA8
`define EGQS_IDX_Q1_RESERVE 8'hA9
`define EGQS_IDX_Q0_RESERVE 8'hAA
`define EGQS_IDX_USAGE_SEL1 8'hAB
`define EGQS_IDX_USAGE_SEL2 8'hAC
`define EGQS_IDX_USAGE_SEL3 8'hAD
`define EGQS_IDX_USAGE_SEL4 8'hAE
`define EGQS_IDX_P1_Q3_DIV 8'hAF
`define EGQS_IDX_P1_Q2_DIV 8'hB0
`define EGQS_IDX_P1_Q1_DIV 8'hB1
`define EGQS_IDX_P1_Q0_DIV 8'hB2

// Field layout
`define EGQS_RATE_MSB 6
`define EGQS_RATE_RESET 7'h00
`define EGQS_DIV_SEL_BIT 7
`define EGQS_DIV_SEL_RESET 1'b1
`define EGQS_CFG_RMII_BIT 4
`define EGQS_CFG_MAC_BIT 2
`define EGQS_CFG_P1_COPPER_BIT 1
`define EGQS_CFG_P2_COPPER_BIT 0

// Fixed read-only words and division low bits
`define EGQS_Q3_RESERVE_VAL 8'h45
`define EGQS_Q2_RESERVE_VAL 8'h35
`define EGQS_Q1_RESERVE_VAL 8'h25
`define EGQS_Q0_RESERVE_VAL 8'h15
`define EGQS_USAGE_SEL1_VAL 8'h58
`define EGQS_USAGE_SEL2_VAL 8'h10
`define EGQS_USAGE_SEL3_VAL 8'h08
`define EGQS_USAGE_SEL4_VAL 8'h05
`define EGQS_DIV_Q3_LOW 7'h08
`define EGQS_DIV_Q2_LOW 7'h04
`define EGQS_DIV_Q1_LOW 7'h02
`define EGQS_DIV_Q0_LOW 7'h01

// Weighted service credits
`define EGQS_WEIGHT_Q3 4'h8
`define EGQS_WEIGHT_Q2 4'h4
`define EGQS_WEIGHT_Q1 4'h2
`define EGQS_WEIGHT_Q0 4'h1

`endif

// ### design/egqs_shaper.v
// Function
// - Port 3 queue-1 seven-bit rate shapes traffic
// - Ports 1-3 queue-2 seven-bit rate fields
// - Ports 1-3 queue-3 seven-bit rate fields
// - Rate bit 7 reserved, reset zero
// - Config word bits 4,2 report port 3
// - Config bits 1,0 report port media
// - Buffer reservation words read-only fixed
// - Usage backpressure words read-only fixed
// - All selects zero, global zero: strict
// - All selects one: weighted 8:4:2:1 or 2:1
// - Port 1 queue 3..0 division selects
`timescale 1ns/1ns
`include "egqs_regs.vh"

module egqs_shaper #(
    parameter ADDR_W = 12,
    parameter NRATE = 7
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire strap_port3_rmii,
    input wire strap_port3_mac_mii,
    input wire strap_port1_copper,
    input wire strap_port2_copper,
    input wire global_weighted_ctl,
    input wire two_queue_mode,
    input wire [3:0] p1_queue_pending,
    input wire p1_tx_slot,
    output reg [NRATE*7-1:0] rate_fields,
    output reg [NRATE-1:0] shape_enable,
    output reg [3:0] p1_queue_grant,
    output reg p1_weighted_mode
);

    ////////////////////////////////////////////////////////////////
    // Strap synchronisers
    // The four configuration pins are board straps.
    // They are static in normal use, but nothing ties
    // them to pclk, so they may move at any moment,
    // during power-up in particular.
    // Two flops in series keep metastability away
    // from the read mux and from software.
    // Only the second stage is read anywhere else.
    // Limitation: a strap change shows two edges late.
    // Reset clears both stages, so the word reads
    // zero until two edges after release.
    // Bit order in both stages:
    // [3] rmii, [2] mac mii, [1] p1 copper, [0] p2 copper.
    reg [3:0] strap_meta_reg;
    reg [3:0] strap_sync_reg;

    // Pins are asynchronous to pclk, two stages before use
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta_reg <= 4'h0;
            strap_sync_reg <= 4'h0;
        end else begin
            strap_meta_reg <= {strap_port3_rmii, strap_port3_mac_mii,
                               strap_port1_copper, strap_port2_copper};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // APB decode
    // Each byte register sits in its own 32-bit word.
    // The word index is paddr[9:2]; the two low
    // address bits are ignored, as are bits above 9.
    // Trade-off: upper address bits are not decoded,
    // so the bank aliases every 1 KB. The bus fabric
    // is expected to gate psel for this window.
    // Only the low byte lane of pwdata is used.
    // Reads return the byte in prdata[7:0] and zero
    // in the upper lanes.
    // The access phase is always one cycle: the
    // answer is registered from the setup cycle.
    // A write lands at the completing edge only, and
    // only when no error is flagged, so a refused
    // write has no side effect on any register.
    wire [7:0] idx;
    wire setup_phase;
    wire wr_commit;
    reg [7:0] rd_word;
    reg rd_hit;
    reg rd_only;
    reg [6:0] rate_idx;

    assign idx = paddr[9:2];
    assign setup_phase = psel & ~penable;
    // Write lands only at the edge that completes the access
    assign wr_commit = psel & penable & pready & pwrite & ~pslverr;

    ////////////////////////////////////////////////////////////////
    // Rate registers, one per shaped queue
    // Seven entries: queues 2 and 3 of ports 1 and 2,
    // and queues 1 to 3 of port 3.
    // Each holds a seven-bit rate code; the code is
    // handed to the shaper unchanged on rate_fields.
    // The shaper maps codes to rates elsewhere.
    // Code zero means the queue runs unshaped, so
    // shape_enable drops for that entry.
    // The reserved top bit is never stored; software
    // writing one there still reads back zero, which
    // keeps the bit at its reset value.
    // rate_fields and shape_enable lag the register
    // by one edge, since outputs come from flops.
    // Entry select is one-hot to keep the generate
    // loop free of any comparison of its own.
    reg [6:0] rate_reg [0:NRATE-1];
    reg [3:0] div_sel_reg;

    // Entry order: p1q2 p1q3 p2q2 p2q3 p3q1 p3q2 p3q3
    always @* begin
        case (idx)
            `EGQS_IDX_P1_Q2_RATE: rate_idx = 7'b0000001;
            `EGQS_IDX_P1_Q3_RATE: rate_idx = 7'b0000010;
            `EGQS_IDX_P2_Q2_RATE: rate_idx = 7'b0000100;
            `EGQS_IDX_P2_Q3_RATE: rate_idx = 7'b0001000;
            `EGQS_IDX_P3_Q1_RATE: rate_idx = 7'b0010000;
            `EGQS_IDX_P3_Q2_RATE: rate_idx = 7'b0100000;
            `EGQS_IDX_P3_Q3_RATE: rate_idx = 7'b1000000;
            default: rate_idx = 7'b0000000;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < NRATE; g = g + 1) begin : gen_rate
            // Bit 7 is not stored, so it reads zero forever
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rate_reg[g] <= `EGQS_RATE_RESET;
                    shape_enable[g] <= 1'b0;
                    rate_fields[g*7+6:g*7] <= `EGQS_RATE_RESET;
                end else begin
                    if (wr_commit && rate_idx[g]) begin
                        rate_reg[g] <= pwdata[`EGQS_RATE_MSB:0];
                    end
                    // Zero means no shaping on that queue
                    shape_enable[g] <= |rate_reg[g];
                    rate_fields[g*7+6:g*7] <= rate_reg[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Division select bits, port 1 queues 3..0
    // Four consecutive words, queue 3 first.
    // Only bit 7 is writable; the low bits are fixed
    // weights and come from constants on read.
    // All four reset to one, so the port starts in
    // weighted service.
    // Strict order needs every bit cleared and the
    // global control low; any mix stays weighted.
    // Hazard: clearing them one at a time passes
    // through mixed states, all of them weighted.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_sel_reg <= {4{`EGQS_DIV_SEL_RESET}};
        end else if (wr_commit) begin
            case (idx)
                `EGQS_IDX_P1_Q3_DIV:
                    div_sel_reg[3] <= pwdata[`EGQS_DIV_SEL_BIT];
                `EGQS_IDX_P1_Q2_DIV:
                    div_sel_reg[2] <= pwdata[`EGQS_DIV_SEL_BIT];
                `EGQS_IDX_P1_Q1_DIV:
                    div_sel_reg[1] <= pwdata[`EGQS_DIV_SEL_BIT];
                `EGQS_IDX_P1_Q0_DIV:
                    div_sel_reg[0] <= pwdata[`EGQS_DIV_SEL_BIT];
                default: div_sel_reg <= div_sel_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read mux
    // Decodes the index during the setup cycle.
    // rd_hit flags a mapped word; rd_only flags a
    // word that software must not write.
    // Buffer reservation and usage backpressure
    // words are fixed constants, not flops.
    // The configuration word shows the synchronised
    // straps; bits 7, 6, 5 and 3 read zero.
    // Default of every path is set at the top, so no
    // latch can form in this process.
    always @* begin
        rd_word = 8'h00;
        rd_hit = 1'b1;
        rd_only = 1'b1;
        case (idx)
            `EGQS_IDX_P1_Q2_RATE: begin
                rd_word = {1'b0, rate_reg[0]};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P1_Q3_RATE: begin
                rd_word = {1'b0, rate_reg[1]};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P2_Q2_RATE: begin
                rd_word = {1'b0, rate_reg[2]};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P2_Q3_RATE: begin
                rd_word = {1'b0, rate_reg[3]};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P3_Q1_RATE: begin
                rd_word = {1'b0, rate_reg[4]};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P3_Q2_RATE: begin
                rd_word = {1'b0, rate_reg[5]};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P3_Q3_RATE: begin
                rd_word = {1'b0, rate_reg[6]};
                rd_only = 1'b0;
            end
            `EGQS_IDX_CFG_REPORT: begin
                rd_word[`EGQS_CFG_RMII_BIT] = strap_sync_reg[3];
                rd_word[`EGQS_CFG_MAC_BIT] = strap_sync_reg[2];
                rd_word[`EGQS_CFG_P1_COPPER_BIT] = strap_sync_reg[1];
                rd_word[`EGQS_CFG_P2_COPPER_BIT] = strap_sync_reg[0];
            end
            `EGQS_IDX_Q3_RESERVE: rd_word = `EGQS_Q3_RESERVE_VAL;
            `EGQS_IDX_Q2_RESERVE: rd_word = `EGQS_Q2_RESERVE_VAL;
            `EGQS_IDX_Q1_RESERVE: rd_word = `EGQS_Q1_RESERVE_VAL;
            `EGQS_IDX_Q0_RESERVE: rd_word = `EGQS_Q0_RESERVE_VAL;
            `EGQS_IDX_USAGE_SEL1: rd_word = `EGQS_USAGE_SEL1_VAL;
            `EGQS_IDX_USAGE_SEL2: rd_word = `EGQS_USAGE_SEL2_VAL;
            `EGQS_IDX_USAGE_SEL3: rd_word = `EGQS_USAGE_SEL3_VAL;
            `EGQS_IDX_USAGE_SEL4: rd_word = `EGQS_USAGE_SEL4_VAL;
            `EGQS_IDX_P1_Q3_DIV: begin
                rd_word = {div_sel_reg[3], `EGQS_DIV_Q3_LOW};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P1_Q2_DIV: begin
                rd_word = {div_sel_reg[2], `EGQS_DIV_Q2_LOW};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P1_Q1_DIV: begin
                rd_word = {div_sel_reg[1], `EGQS_DIV_Q1_LOW};
                rd_only = 1'b0;
            end
            `EGQS_IDX_P1_Q0_DIV: begin
                rd_word = {div_sel_reg[0], `EGQS_DIV_Q0_LOW};
                rd_only = 1'b0;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Answer one cycle after setup, so access phase is one cycle
    // pready and pslverr stand for exactly the access
    // cycle and drop again after it; prdata holds.
    // A master that inserts idle cycles between
    // transfers sees nothing until its next setup.
    // Read data is zero on writes and on errors, so
    // a failed read never leaks a stale value.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                // Unmapped index or write to a fixed word is an error
                pslverr <= ~rd_hit | (pwrite & rd_only);
                prdata <= (pwrite | ~rd_hit) ? 32'h00000000
                                              : {24'h000000, rd_word};
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Port 1 egress scheduler
    // Each transmit opportunity picks one queue.
    // Strict service: highest pending queue wins.
    // Weighted service: each queue holds a credit
    // count, loaded with its weight at round start.
    // A grant spends one credit; the highest queue
    // that is pending and has credit wins.
    // The round ends when no pending queue has any
    // credit left; all credits reload at once then.
    // Two-queue mode serves queues 1 and 0 only,
    // with weights 2 and 1.
    // Limitation: credits survive a switch between
    // strict and weighted, so the first weighted
    // round after strict may be a partial one.
    // Credits reset to zero, so the first weighted
    // grant after reset always starts a fresh round.
    reg [3:0] credit_reg [0:3];
    reg [3:0] weight [0:3];
    reg [3:0] pend_eff;
    reg [3:0] elig;
    reg [3:0] pick;
    reg reload;
    reg strict_mode;
    integer i;
    integer j;

    always @* begin
        weight[3] = two_queue_mode ? 4'h0 : `EGQS_WEIGHT_Q3;
        weight[2] = two_queue_mode ? 4'h0 : `EGQS_WEIGHT_Q2;
        weight[1] = `EGQS_WEIGHT_Q1;
        weight[0] = `EGQS_WEIGHT_Q0;
        // Strict only when every select and the global bit are clear
        strict_mode = (div_sel_reg == 4'h0) & ~global_weighted_ctl;
        pend_eff = two_queue_mode ? (p1_queue_pending & 4'h3)
                                  : p1_queue_pending;
        for (i = 0; i < 4; i = i + 1) begin
            elig[i] = pend_eff[i] & (credit_reg[i] != 4'h0);
        end
        // A round ends when nobody pending has credit left
        reload = (elig == 4'h0);
        if (!strict_mode && reload) begin
            elig = pend_eff & {weight[3] != 4'h0, weight[2] != 4'h0,
                               1'b1, 1'b1};
        end
        if (strict_mode) begin
            elig = pend_eff;
        end
        // Highest eligible queue first
        if (elig[3]) pick = 4'b1000;
        else if (elig[2]) pick = 4'b0100;
        else if (elig[1]) pick = 4'b0010;
        else if (elig[0]) pick = 4'b0001;
        else pick = 4'b0000;
    end

    // Credits spend one per grant; refilled at round end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (j = 0; j < 4; j = j + 1) begin
                credit_reg[j] <= 4'h0;
            end
            p1_queue_grant <= 4'h0;
            p1_weighted_mode <= 1'b1;
        end else begin
            p1_weighted_mode <= ~strict_mode;
            p1_queue_grant <= p1_tx_slot ? pick : 4'h0;
            if (p1_tx_slot && !strict_mode && pick != 4'h0) begin
                for (j = 0; j < 4; j = j + 1) begin
                    if (reload) begin
                        credit_reg[j] <= pick[j] ? weight[j] - 4'h1
                                                 : weight[j];
                    end else if (pick[j]) begin
                        credit_reg[j] <= credit_reg[j] - 4'h1;
                    end
                end
            end
        end
    end

endmodule

// ### verification/egqs_shaper_asserts.sv
`timescale 1ns/1ns
`include "egqs_regs.vh"
module egqs_chk #(
    parameter ADDR_W = 12,
    parameter NRATE = 7
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire global_weighted_ctl,
    input wire [3:0] p1_queue_pending,
    input wire p1_tx_slot,
    input wire [NRATE*7-1:0] rate_fields,
    input wire [NRATE-1:0] shape_enable,
    input wire [3:0] p1_queue_grant,
    input wire p1_weighted_mode
);
    // Completed transfer of either direction
    wire [7:0] idx = paddr[9:2];
    wire rd = psel && pready && !pwrite;
    wire wr = psel && pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    p3q1_follow_a:
        assert property (wr && idx == `EGQS_IDX_P3_Q1_RATE |-> ##2
            rate_fields[34:28] == $past(pwdata[6:0], 2))
        else $error("port 3 queue 1 rate field wrong");
    p1q2_follow_a:
        assert property (wr && idx == `EGQS_IDX_P1_Q2_RATE |-> ##2
            rate_fields[6:0] == $past(pwdata[6:0], 2))
        else $error("port 1 queue 2 rate field wrong");
    shape_zero_a:
        assert property (shape_enable[0] == |rate_fields[6:0])
        else $error("shape enable disagrees with rate");
    rate_top_a:
        assert property (rd && idx >= 8'h9C && idx <= 8'hA5
            |-> prdata[31:7] == 25'h0)
        else $error("rate top bit not zero");
    ro_write_a:
        assert property (wr && idx >= 8'hA6 && idx <= 8'hAE |-> pslverr)
        else $error("read-only write accepted");
    q3_reserve_a:
        assert property (rd && idx == `EGQS_IDX_Q3_RESERVE
            |-> prdata == 32'h00000045)
        else $error("queue 3 reservation wrong");
    usage4_val_a:
        assert property (rd && idx == `EGQS_IDX_USAGE_SEL4
            |-> prdata == 32'h00000005 && !pslverr)
        else $error("usage select 4 wrong");
    strict_top_a:
        assert property (p1_tx_slot && !p1_weighted_mode &&
            p1_queue_pending[3] |=> p1_queue_grant == 4'h8)
        else $error("strict order broken");
    global_wt_a:
        assert property (global_weighted_ctl [*2] |-> p1_weighted_mode)
        else $error("global control ignored");
    grant_legal_a:
        assert property (p1_tx_slot |=> $onehot0(p1_queue_grant) &&
            (p1_queue_grant & ~$past(p1_queue_pending)) == 4'h0)
        else $error("grant to idle queue");
    cover property (p1_tx_slot && p1_weighted_mode);
    cover property (p1_tx_slot && !p1_weighted_mode);
    cover property (wr && pslverr);
endmodule
bind egqs_shaper egqs_chk #(.ADDR_W(ADDR_W), .NRATE(NRATE)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_weighted_ctl(global_weighted_ctl),
    .p1_queue_pending(p1_queue_pending), .p1_tx_slot(p1_tx_slot),
    .rate_fields(rate_fields), .shape_enable(shape_enable),
    .p1_queue_grant(p1_queue_grant), .p1_weighted_mode(p1_weighted_mode)
);

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, p1_tx_slot;
    logic global_weighted_ctl, two_queue_mode, p1_weighted_mode;
    logic slot_q = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] straps, p1_queue_pending, p1_queue_grant;
    logic [48:0] rate_fields;
    logic [6:0] shape_enable;
    logic [7:0] d;
    logic [32:0] eq[$], gq[$];
    int err_total, n_compared, seed, k;
    logic [7:0] rix [7] = '{8'h9C, 8'h9D, 8'hA0, 8'hA1, 8'hA3, 8'hA4, 8'hA5};
    logic [15:0] tbl [19] = '{16'h9C00, 16'h9D00, 16'hA000, 16'hA100,
        16'hA300, 16'hA400, 16'hA500, 16'hA745, 16'hA835, 16'hA925,
        16'hAA15, 16'hAB58, 16'hAC10, 16'hAD08, 16'hAE05, 16'hAF88,
        16'hB084, 16'hB182, 16'hB281};
    egqs_shaper DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .strap_port3_rmii(straps[3]), .strap_port3_mac_mii(straps[2]),
        .strap_port1_copper(straps[1]), .strap_port2_copper(straps[0]),
        .global_weighted_ctl(global_weighted_ctl),
        .two_queue_mode(two_queue_mode),
        .p1_queue_pending(p1_queue_pending), .p1_tx_slot(p1_tx_slot),
        .rate_fields(rate_fields), .shape_enable(shape_enable),
        .p1_queue_grant(p1_queue_grant), .p1_weighted_mode(p1_weighted_mode)
    );
    // 25 MHz clock
    initial forever #20 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One transfer; the wait is bounded, never a fixed latency
    task automatic apb(input logic w, input logic [7:0] i,
        input logic [7:0] v, input logic [32:0] e);
        int n = 0;
        r = $random(seed);
        eq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {r[31:8], v};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) begin
            err_total++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic sch(input logic [3:0] p, input logic [3:0] g);
        p1_queue_pending <= p;
        p1_tx_slot <= 1'b1;
        gq.push_back({29'h0, g});
        @(posedge pclk);
    endtask
    // Monitor: pops the oldest note when a result shows
    always @(posedge pclk) begin
        if (pready === 1'b1) cmp({pslverr, prdata}, eq.pop_front());
        if (slot_q === 1'b1) cmp({29'h0, p1_queue_grant}, gq.pop_front());
        slot_q = p1_tx_slot;
    end
    // Watchdog, well beyond the few hundred cycles needed
    initial begin
        repeat (3000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h31AC;
        {presetn, psel, penable, pwrite, p1_tx_slot} = 5'h0;
        {global_weighted_ctl, two_queue_mode} = 2'h0;
        {paddr, pwdata, straps, p1_queue_pending} = 52'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 19; k++)
            apb(1'b0, tbl[k][15:8], 8'h00, {25'h0, tbl[k][7:0]});
        repeat (4) begin
            r = $random(seed);
            straps <= r[3:0];
            repeat (3) @(posedge pclk);
            apb(1'b0, 8'hA6, 8'h00, {28'h0, straps[3], 1'b0, straps[2:0]});
        end
        // Top bit set on purpose; first entry written zero
        for (k = 0; k < 7; k++) begin
            r = $random(seed);
            d = (k == 0) ? 8'h80 : (r[7:0] | 8'h80);
            apb(1'b1, rix[k], d, 33'h0);
            apb(1'b0, rix[k], 8'h00, {26'h0, d[6:0]});
            cmp({26'h0, rate_fields[k*7+:7]}, {26'h0, d[6:0]});
            cmp({32'h0, shape_enable[k]}, {32'h0, |d[6:0]});
        end
        apb(1'b1, 8'hA7, 8'h00, {1'b1, 32'h0});
        apb(1'b1, 8'hAE, 8'hFF, {1'b1, 32'h0});
        apb(1'b0, 8'hA7, 8'h00, 33'h045);
        apb(1'b0, 8'h9E, 8'h00, {1'b1, 32'h0});
        for (k = 3; k >= 0; k--)
            repeat (1 << k) sch(4'hF, 4'h1 << k);
        two_queue_mode <= 1'b1;
        for (k = 1; k >= 0; k--)
            repeat (1 << k) sch(4'h3, 4'h1 << k);
        sch(4'h0, 4'h0);
        p1_tx_slot <= 1'b0;
        two_queue_mode <= 1'b0;
        // Strict needs every select cleared
        for (k = 0; k < 4; k++) begin
            apb(1'b1, 8'hAF + k[7:0], 8'h00, 33'h0);
            @(posedge pclk);
            cmp({32'h0, p1_weighted_mode}, {32'h0, k != 3});
        end
        apb(1'b0, 8'hAF, 8'h00, 33'h008);
        repeat (8) begin
            r = $random(seed);
            sch(r[3:0], r[3] ? 4'h8 : r[2] ? 4'h4 : r[1] ? 4'h2 : {3'h0, r[0]});
        end
        p1_tx_slot <= 1'b0;
        global_weighted_ctl <= 1'b1;
        repeat (2) @(posedge pclk);
        cmp({32'h0, p1_weighted_mode}, 33'h1);
        repeat (3) @(posedge pclk);
        report_and_stop();
    end
endmodule
